// ### lintr_pkg.sv
// Constants, codes and timing shared by the single-wire link block.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
//
// What this block does
// - Transceivers start off; off always selectable
// - Off mode ignores bus wake patterns
// - Separate mode field per transceiver, software-written
// - Normal mode only in system normal/stop
// - Normal mode: transmit low drives dominant
// - Early dominant suppressed; next dominant bit sent
// - Receive-only: driver off, receiver follows bus
// - Wake mode selectable; forced on fail-safe entry
// - Wake on rising edge after long dominant
// - Wake filter between 30 and 150 us
// - After wake, receive low until mode changes
// - Field still reads wake code; no rewake
// - Rearm by leaving then reselecting wake mode
// - Rearm on stop, sleep or fail-safe entry
// - Wake in stop/normal: interrupt, flag, receive low
// - Stop wake stays in stop mode
// - Stop wake enables watchdog if bit set
// - Sleep wake goes restart, supply up, no interrupt
// - Fail-safe/restart wake: restart, interrupt stays high
// - Transmit stuck dominant disables driver temporarily
// - Transmit time-out sets channel fault flag
// - Driver re-enabled once transmit released
package lintr_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ       = 25_000_000;  // Core clock rate
    localparam int WAKE_FILT_US = 30;          // Least dominant time for a wake
    localparam int LIN_EN_US    = 18;          // Transceiver enabling time
    localparam int TXTO_MS      = 20;          // Transmit dominant time-out
    localparam int WAKE_FILT_CYC = (WAKE_FILT_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int LIN_EN_CYC    = (LIN_EN_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int TXTO_DEF_CYC  = TXTO_MS * (CLK_HZ / 1000);
    localparam int CNT_W         = 20;         // Width of every timer

    // ==========================================================
    // Transceiver mode codes
    // ==========================================================
    localparam logic [1:0] MODE_OFF  = 2'h0;   // Off, reset value
    localparam logic [1:0] MODE_WAKE = 2'h1;   // Wake capable
    localparam logic [1:0] MODE_NORM = 2'h2;   // Normal transmit and receive
    localparam logic [1:0] MODE_RXO  = 2'h3;   // Receive only

    // ==========================================================
    // Register map and fields
    // ==========================================================
    localparam logic [7:0] ADR_CTRL  = 8'h00;  // Mode fields and watchdog bits
    localparam logic [7:0] ADR_SYS   = 8'h04;  // System operating mode
    localparam logic [7:0] ADR_FAULT = 8'h08;  // Fault flags, clear on read
    localparam logic [7:0] ADR_WAKE  = 8'h0C;  // Wake status, clear on read
    localparam int CTRL_MODE_LSB = 0;          // Channel n field at 2n
    localparam int CTRL_WDW_BIT  = 4;          // Watchdog on bus wake
    localparam int CTRL_WDEN_BIT = 5;          // Watchdog enable
    localparam logic CTRL_WDW_RST  = 1'b0;     // Reset of watchdog-on-wake
    localparam logic CTRL_WDEN_RST = 1'b0;     // Reset of watchdog enable

    // ==========================================================
    // System operating modes
    // ==========================================================
    typedef enum logic [4:0] {
        SYS_NORMAL   = 5'h01,
        SYS_STOP     = 5'h02,
        SYS_SLEEP    = 5'h04,
        SYS_RESTART  = 5'h08,
        SYS_FAILSAFE = 5'h10
    } lintr_sys_t;

endpackage

// ### lintr_chan.sv
// One transceiver channel: enabling, transmit gating, time-out, wake.
// Assumes mode comes from a register and rearm is a one-cycle pulse.
module lintr_chan
    import lintr_pkg::*;
#(
    parameter logic [CNT_W-1:0] TXTO_CYC = CNT_W'(TXTO_DEF_CYC)
)
(
    input  wire logic       clk,          // Core clock
    input  wire logic       rst,          // Sync reset, high
    input  wire logic [1:0] mode,         // Current mode field
    input  wire logic       rearm,        // Automatic rearm pulse
    input  wire logic       txd,          // Transmit input, low = dominant
    input  wire logic       bus,          // Bus level, low = dominant
    output logic            drive_dom_q,  // Drive bus dominant
    output logic            rxd_q,        // Receive output
    output logic            wake_p_q,     // Wake detected pulse
    output logic            fault_p_q     // Time-out fault pulse
);

    // ==========================================================
    // Decode
    // ==========================================================
    logic             in_norm;     // Normal mode selected
    logic             in_wake;     // Wake-capable mode selected
    logic [CNT_W-1:0] en_cnt_q;    // Enabling timer
    logic             en_done;     // Enabling time elapsed
    logic             tx_ok_q;     // Transmit released after enabling
    logic [CNT_W-1:0] to_cnt_q;    // Dominant time-out timer
    logic             to_hit;      // Time-out active
    logic             bus_q;       // Previous bus level
    logic             dom_q;       // Dominant phase opened by an edge
    logic [CNT_W-1:0] wk_cnt_q;    // Dominant length, saturating
    logic             woken_q;     // Woken, detection disarmed
    logic             wake_ev;     // Wake event this cycle

    assign in_norm = (mode == MODE_NORM);
    assign in_wake = (mode == MODE_WAKE);
    assign en_done = (en_cnt_q == CNT_W'(LIN_EN_CYC));
    assign to_hit  = (to_cnt_q == TXTO_CYC);

    // ==========================================================
    // Enabling sequence
    // ==========================================================
    // Enabling timer restarts whenever normal mode is left
    always_ff @(posedge clk)
    begin
        if (rst || !in_norm)
            en_cnt_q <= '0;
        else if (!en_done)
            en_cnt_q <= en_cnt_q + CNT_W'(1);
    end

    // A low seen too early is held off until a high is seen
    always_ff @(posedge clk)
    begin
        if (rst || !in_norm)
            tx_ok_q <= 1'b0;
        else if (en_done && txd)
            tx_ok_q <= 1'b1;
    end

    // ==========================================================
    // Transmit time-out
    // ==========================================================
    // Counts low cycles; a high input clears it at once
    always_ff @(posedge clk)
    begin
        if (rst || txd || !in_norm)
            to_cnt_q <= '0;
        else if (!to_hit)
            to_cnt_q <= to_cnt_q + CNT_W'(1);
    end

    // Fault pulse on the cycle the time-out is reached
    always_ff @(posedge clk)
    begin
        if (rst)
            fault_p_q <= 1'b0;
        else
            fault_p_q <= in_norm && !txd && (to_cnt_q == TXTO_CYC - CNT_W'(1));
    end

    // Driver: only in normal mode, enabled, not timed out
    always_ff @(posedge clk)
    begin
        if (rst)
            drive_dom_q <= 1'b0;
        else
            drive_dom_q <= in_norm && tx_ok_q && !txd && !to_hit;
    end

    // ==========================================================
    // Bus wake detection
    // ==========================================================
    assign wake_ev = in_wake && !woken_q && dom_q && bus && !bus_q
                     && (wk_cnt_q == CNT_W'(WAKE_FILT_CYC));

    // Edge tracking; a dominant level without an edge never counts
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_q    <= 1'b1;
            dom_q    <= 1'b0;
            wk_cnt_q <= '0;
        end
        else
        begin
            bus_q <= bus;
            if (bus)
            begin
                dom_q    <= 1'b0;
                wk_cnt_q <= '0;
            end
            else if (bus_q)
            begin
                dom_q    <= 1'b1;
                wk_cnt_q <= CNT_W'(1);
            end
            else if (wk_cnt_q != CNT_W'(WAKE_FILT_CYC))
                wk_cnt_q <= wk_cnt_q + CNT_W'(1);
        end
    end

    // Woken state: set wins over a rearm in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            woken_q <= 1'b0;
        else if (wake_ev)
            woken_q <= 1'b1;
        else if (!in_wake || rearm)
            woken_q <= 1'b0;
    end

    // Receive output per mode; off and idle wake read high
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rxd_q    <= 1'b1;
            wake_p_q <= 1'b0;
        end
        else
        begin
            wake_p_q <= wake_ev;
            if (in_norm || mode == MODE_RXO)
                rxd_q <= bus;
            else if (in_wake)
                rxd_q <= !(woken_q || wake_ev);
            else
                rxd_q <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_drive_needs_norm;
        @(posedge clk) disable iff (rst)
        !in_norm |=> !drive_dom_q;
    endproperty
    a_drive_needs_norm: assert property (p_drive_needs_norm)
        else $error("Driver active outside normal mode");

    property p_timeout_release;
        @(posedge clk) disable iff (rst)
        fault_p_q |=> !drive_dom_q ##1 !drive_dom_q;
    endproperty
    a_timeout_release: assert property (p_timeout_release)
        else $error("Driver still active after time-out");

    property p_wake_low;
        @(posedge clk) disable iff (rst)
        wake_p_q && in_wake |-> !rxd_q;
    endproperty
    a_wake_low: assert property (p_wake_low)
        else $error("Receive output not low after wake");

    property p_no_early_drive;
        @(posedge clk) disable iff (rst)
        $rose(in_norm) |-> !drive_dom_q [*8];
    endproperty
    a_no_early_drive: assert property (p_no_early_drive)
        else $error("Driver active during enabling");

endmodule

// ### lintr_top.sv
// Mode, wake and fault control for two single-wire link transceivers.
// Assumes all pins are synchronous to CLK and a simple strobe bus master.
module lintr_top
    import lintr_pkg::*;
#(
    parameter logic [CNT_W-1:0] TXTO_CYC = CNT_W'(TXTO_DEF_CYC)  // Time-out cycles
)
(
    input  wire logic        CLK,            // 25 MHz clock
    input  wire logic        RST,            // Sync reset, high
    input  wire logic [7:0]  ADDR,           // Register byte address
    input  wire logic [31:0] WDATA,          // Write data
    input  wire logic        WR,             // Write strobe
    input  wire logic        RD,             // Read strobe
    output logic      [31:0] RDATA,          // Read data, cycle after RD
    input  wire logic [1:0]  TXD,            // Transmit inputs, low = dominant
    input  wire logic [1:0]  LIN_BUS,        // Bus levels, low = dominant
    input  wire logic        FAILSAFE_REQ,   // Request system fail-safe
    output logic      [1:0]  LIN_DRIVE_DOM,  // Drive bus dominant
    output logic      [1:0]  RXD,            // Receive outputs
    output logic             INT_N,          // Interrupt, low active
    output logic             MAIN_SUPPLY_ON, // Main supply enable
    output logic             WATCHDOG_EN,    // Watchdog enabled
    output logic      [4:0]  SYS_MODE        // System mode, one-hot
);

    // ==========================================================
    // State
    // ==========================================================
    lintr_sys_t  sys_q;          // System operating mode
    lintr_sys_t  sys_d;          // Next system mode
    logic [1:0]  mode_q [2];     // Mode field per channel
    logic        wdw_q;          // Watchdog-on-bus-wake bit
    logic        wden_q;         // Watchdog enable
    logic [1:0]  fault_q;        // Sticky fault flags
    logic [1:0]  wake_q;         // Sticky wake status
    logic        int_n_q;        // Interrupt pin
    logic        supply_q;       // Main supply enable
    logic [31:0] rdata_q;        // Read data register
    logic [1:0]  drive_w;        // Channel driver flops
    logic [1:0]  rxd_w;          // Channel receive flops
    logic [1:0]  wake_p;         // Channel wake pulses
    logic [1:0]  fault_p;        // Channel fault pulses
    logic        any_wake;       // Any channel woke
    logic        sys_enter;      // System mode changes now
    logic        rearm;          // Automatic rearm pulse
    logic        wr_ctrl;        // Control register write
    logic        wr_sys;         // System mode write
    logic        rd_fault;       // Fault register read
    logic        rd_wake;        // Wake register read
    logic        sys_code_ok;    // Written system code legal
    logic        norm_or_stop;   // System in normal or stop

    assign any_wake     = |wake_p;
    assign wr_ctrl      = WR && (ADDR == ADR_CTRL);
    assign wr_sys       = WR && (ADDR == ADR_SYS);
    assign rd_fault     = RD && (ADDR == ADR_FAULT);
    assign rd_wake      = RD && (ADDR == ADR_WAKE);
    assign norm_or_stop = (sys_q == SYS_NORMAL) || (sys_q == SYS_STOP);
    assign sys_code_ok  = (WDATA[4:0] inside {SYS_NORMAL, SYS_STOP, SYS_SLEEP,
                                              SYS_RESTART, SYS_FAILSAFE});

    // ==========================================================
    // System mode
    // ==========================================================
    // Fail-safe request first, then wake reactions, then software
    always_comb
    begin
        sys_d = sys_q;
        if (FAILSAFE_REQ)
            sys_d = SYS_FAILSAFE;
        else if (any_wake && (sys_q == SYS_SLEEP || sys_q == SYS_FAILSAFE))
            sys_d = SYS_RESTART;
        else if (wr_sys && sys_code_ok)
            sys_d = lintr_sys_t'(WDATA[4:0]);
    end

    // Mode register; a stop wake never leaves stop by itself
    always_ff @(posedge CLK)
    begin
        if (RST)
            sys_q <= SYS_NORMAL;
        else
            sys_q <= sys_d;
    end

    assign sys_enter = (sys_d != sys_q);
    // Entering any low-power or fail-safe mode rearms wake detection
    assign rearm = sys_enter && (sys_d == SYS_STOP || sys_d == SYS_SLEEP
                                 || sys_d == SYS_FAILSAFE);

    // Supply off in sleep and fail-safe; restart ramps it up
    always_ff @(posedge CLK)
    begin
        if (RST)
            supply_q <= 1'b1;
        else
            supply_q <= !(sys_d == SYS_SLEEP || sys_d == SYS_FAILSAFE);
    end

    // ==========================================================
    // Per-channel mode fields and transceivers
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_chan
            logic [1:0] new_mode;   // Requested code
            logic       allowed;    // Code legal in this system mode

            assign new_mode = WDATA[CTRL_MODE_LSB + 2*gi +: 2];
            // Off anywhere; wake outside fail-safe; active modes only normal/stop
            assign allowed  = (new_mode == MODE_OFF)
                              || (new_mode == MODE_WAKE && sys_q != SYS_FAILSAFE)
                              || norm_or_stop;

            // Mode field: forced entries win over software writes
            always_ff @(posedge CLK)
            begin
                if (RST)
                    mode_q[gi] <= MODE_OFF;
                else if (sys_enter && sys_d == SYS_FAILSAFE)
                    mode_q[gi] <= MODE_WAKE;
                else if (sys_enter && (sys_d == SYS_SLEEP || sys_d == SYS_RESTART)
                         && (mode_q[gi] == MODE_NORM || mode_q[gi] == MODE_RXO))
                    mode_q[gi] <= MODE_WAKE;
                else if (wr_ctrl && allowed)
                    mode_q[gi] <= new_mode;
            end

            // Fault flag: set wins over clear-on-read
            always_ff @(posedge CLK)
            begin
                if (RST)
                    fault_q[gi] <= 1'b0;
                else if (fault_p[gi])
                    fault_q[gi] <= 1'b1;
                else if (rd_fault)
                    fault_q[gi] <= 1'b0;
            end

            // Wake status: set wins over clear-on-read
            always_ff @(posedge CLK)
            begin
                if (RST)
                    wake_q[gi] <= 1'b0;
                else if (wake_p[gi])
                    wake_q[gi] <= 1'b1;
                else if (rd_wake)
                    wake_q[gi] <= 1'b0;
            end

            lintr_chan #(
                .TXTO_CYC (TXTO_CYC)
            ) u_chan (
                .clk         (CLK),
                .rst         (RST),
                .mode        (mode_q[gi]),
                .rearm       (rearm),
                .txd         (TXD[gi]),
                .bus         (LIN_BUS[gi]),
                .drive_dom_q (drive_w[gi]),
                .rxd_q       (rxd_w[gi]),
                .wake_p_q    (wake_p[gi]),
                .fault_p_q   (fault_p[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Watchdog and interrupt
    // ==========================================================
    // Watchdog bits; a stop wake may switch the watchdog on
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wdw_q  <= CTRL_WDW_RST;
            wden_q <= CTRL_WDEN_RST;
        end
        else
        begin
            if (wr_ctrl)
                wdw_q <= WDATA[CTRL_WDW_BIT];
            if (any_wake && sys_q == SYS_STOP && wdw_q)
                wden_q <= 1'b1;
            else if (wr_ctrl)
                wden_q <= WDATA[CTRL_WDEN_BIT];
        end
    end

    // Interrupt only for wakes in normal or stop; read releases it
    always_ff @(posedge CLK)
    begin
        if (RST)
            int_n_q <= 1'b1;
        else if (any_wake && norm_or_stop)
            int_n_q <= 1'b0;
        else if (rd_wake)
            int_n_q <= 1'b1;
    end

    // ==========================================================
    // Register read port
    // ==========================================================
    // Data stand only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK)
    begin
        if (RST || !RD)
            rdata_q <= 32'h0;
        else
        begin
            unique case (ADDR)
                ADR_CTRL:  rdata_q <= {26'h0, wden_q, wdw_q,
                                       mode_q[1], mode_q[0]};
                ADR_SYS:   rdata_q <= {27'h0, sys_q};
                ADR_FAULT: rdata_q <= {30'h0, fault_q};
                ADR_WAKE:  rdata_q <= {30'h0, wake_q};
                default:   rdata_q <= 32'h0;
            endcase
        end
    end

    assign RDATA          = rdata_q;
    assign LIN_DRIVE_DOM  = drive_w;
    assign RXD            = rxd_w;
    assign INT_N          = int_n_q;
    assign MAIN_SUPPLY_ON = supply_q;
    assign WATCHDOG_EN    = wden_q;
    assign SYS_MODE       = sys_q;

    // ==========================================================
    // Checks
    // ==========================================================
    property p_sleep_wake;
        @(posedge CLK) disable iff (RST)
        any_wake && sys_q == SYS_SLEEP && !FAILSAFE_REQ
            |=> sys_q == SYS_RESTART && MAIN_SUPPLY_ON && INT_N;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("Sleep wake did not restart quietly");

    property p_stop_wake;
        @(posedge CLK) disable iff (RST)
        any_wake && sys_q == SYS_STOP && !FAILSAFE_REQ && !wr_sys
            |=> sys_q == SYS_STOP && !INT_N && wake_q != 2'h0;
    endproperty
    a_stop_wake: assert property (p_stop_wake)
        else $error("Stop wake not signalled");

    property p_failsafe_wake_mode;
        @(posedge CLK) disable iff (RST)
        sys_enter && sys_d == SYS_FAILSAFE
            |=> mode_q[0] == MODE_WAKE && mode_q[1] == MODE_WAKE && !MAIN_SUPPLY_ON;
    endproperty
    a_failsafe_wake_mode: assert property (p_failsafe_wake_mode)
        else $error("Fail-safe entry did not force wake mode");

    property p_wd_on_wake;
        @(posedge CLK) disable iff (RST)
        any_wake && sys_q == SYS_STOP && wdw_q |=> WATCHDOG_EN;
    endproperty
    a_wd_on_wake: assert property (p_wd_on_wake)
        else $error("Watchdog not enabled by stop wake");

    property p_norm_blocked;
        @(posedge CLK) disable iff (RST)
        wr_ctrl && !norm_or_stop && !sys_enter && WDATA[1:0] == MODE_NORM
            |=> mode_q[0] == $past(mode_q[0]);
    endproperty
    a_norm_blocked: assert property (p_norm_blocked)
        else $error("Normal mode accepted in wrong system mode");

endmodule

// ### lintr_mcu.sv
// Controller model: drives one transmit pin of the link block.
// Assumes a start pulse in the cycle that normal mode is written.
module lintr_mcu
    import lintr_pkg::*;
(
    input  wire logic clk,   // Core clock
    input  wire logic start, // Normal mode just selected
    input  wire logic rude,  // Skip the enabling wait on purpose
    input  wire logic dom,   // Wish to send dominant
    output logic      txd_q  // Transmit pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Enabling wait
    // ==========================================
    int wait_q = 0;          // Cycles since start
    // Recessive until enabling is surely over
    always_ff @(posedge clk)
    begin
        wait_q <= start ? 0 : wait_q + 1;
        txd_q  <= (wait_q < LIN_EN_CYC + 2 && !rude) ? 1'b1 : !dom;
    end
endmodule

// ### tb_top.sv
// Bench: register port, enabling, time-out and wake reactions.
// Assumes the controller model drives channel 0 transmit.
module tb_top
    import lintr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] d, e;} lintr_row_t;
    lintr_row_t rows [4] = '{'{ADR_CTRL, 32'h0F, 32'h0F}, '{ADR_CTRL, 32'h0A, 32'h0A},
        '{ADR_SYS, 32'h01, 32'h01}, '{8'h10, 32'hFF, 32'h00}};
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        rude = 1'b1, dom = 1'b0, start = 1'b0, fsr = 1'b0, txd2 = 1'b1, mtxd;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bus = 2'h3, drv, rxd;
    logic        int_n, sup, wde;
    logic [4:0]  sysm;
    int          n_mismatch = 0, checks = 0, cyc = 0;
    always #20 clk = !clk;
    // Time-out longer than the enabling wait, so a blocked early low is not masked by it
    lintr_top #(.TXTO_CYC(20'd600)) dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .TXD({txd2, mtxd}), .LIN_BUS(bus),
        .FAILSAFE_REQ(fsr), .LIN_DRIVE_DOM(drv), .RXD(rxd), .INT_N(int_n),
        .MAIN_SUPPLY_ON(sup), .WATCHDOG_EN(wde), .SYS_MODE(sysm));
    lintr_mcu mcu (.clk(clk), .start(start), .rude(rude), .dom(dom), .txd_q(mtxd));
    task chk(input logic [31:0] g, e);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task bus_rd(input logic [7:0] a, input logic [31:0] e, m);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Long dominant phase, then back to recessive
    task wake_pulse();
        @(posedge clk);
        bus <= 2'h0;
        wait_n(WAKE_FILT_CYC + 5);
        bus <= 2'h3;
        wait_n(4);
    endtask
    task give_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, a little over twice the expected run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial
    begin
        wait_n(4);
        rst <= 1'b0;
        chk({sysm, int_n, sup, wde, rxd, drv}, {5'h01, 7'h6C});
        bus_rd(ADR_CTRL, 32'h0, 32'h0F);
        foreach (rows[i])
        begin
            bus_wr(rows[i].a, rows[i].d);
            bus_rd(rows[i].a, rows[i].e, 32'hFF);
        end
        $display("test registers done");
        bus_wr(ADR_CTRL, 32'h00);
        bus_wr(ADR_CTRL, 32'h02);
        start <= 1'b1;
        dom   <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wait_n(LIN_EN_CYC + 10);
        chk(drv, 2'h0);
        bus_rd(ADR_FAULT, 32'h0, 32'h3);
        {rude, dom} <= 2'h0;
        wait_n(3);
        dom <= 1'b1;
        wait_n(3);
        chk(drv, 2'h1);
        wait_n(610);
        chk(drv, 2'h0);
        bus_rd(ADR_FAULT, 32'h1, 32'h3);
        bus_rd(ADR_CTRL, 32'h2, 32'hF);
        dom <= 1'b0;
        wait_n(3);
        dom <= 1'b1;
        wait_n(3);
        chk(drv, 2'h1);
        dom <= 1'b0;
        $display("test transmit done");
        bus_wr(ADR_CTRL, 32'h11);
        bus_wr(ADR_SYS, 32'h02);
        wake_pulse();
        chk({sysm, int_n, wde, rxd}, {5'h02, 4'h6});
        bus_rd(ADR_CTRL, 32'h1, 32'h3);
        bus_rd(ADR_WAKE, 32'h1, 32'h3);
        bus_wr(ADR_SYS, 32'h04);
        wake_pulse();
        chk({sysm, int_n, rxd[0]}, {5'h08, 2'h2});
        // Fail-safe entry forces wake mode on both and rearms them
        fsr <= 1'b1;
        wait_n(1);
        fsr <= 1'b0;
        wait_n(2);
        chk({sysm, sup, rxd}, {5'h10, 3'h3});
        bus_rd(ADR_CTRL, 32'h5, 32'hF);
        wake_pulse();
        chk({sysm, int_n, sup, rxd}, {5'h08, 4'hC});
        bus_wr(ADR_CTRL, 32'h0A);
        bus_rd(ADR_CTRL, 32'h5, 32'hF);
        $display("test wake done");
        give_verdict();
    end
endmodule
